// File: fsw_pad.sv
// spare file intentionally empty of logic
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// File: fsw_pkg.sv
// constants and types shared by the flash status protection block
package fsw_pkg;
    // instruction codes seen on the serial bus
    localparam logic [7:0] OP_WR_EN = 8'h06;
    localparam logic [7:0] OP_WR_DIS = 8'h04;
    localparam logic [7:0] OP_RD_S1 = 8'h05;
    localparam logic [7:0] OP_RD_S2 = 8'h35;
    localparam logic [7:0] OP_RD_S3 = 8'h15;
    localparam logic [7:0] OP_WR_S1 = 8'h01;
    localparam logic [7:0] OP_WR_S2 = 8'h31;
    localparam logic [7:0] OP_WR_S3 = 8'h11;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_PREFIX_A = 8'haa;
    localparam logic [7:0] OP_PREFIX_B = 8'h55;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_QPROG = 8'h32;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_64K = 8'hd8;
    localparam logic [7:0] OP_CHIP_A = 8'hc7;
    localparam logic [7:0] OP_CHIP_B = 8'h60;
    localparam logic [7:0] OP_LOCK_ONE = 8'h36;
    localparam logic [7:0] OP_UNLOCK_ONE = 8'h39;
    localparam logic [7:0] OP_LOCK_ALL = 8'h7e;
    localparam logic [7:0] OP_UNLOCK_ALL = 8'h98;
    // bit positions inside the three status bytes
    localparam int B1_WR_EN = 1;
    localparam int B1_RANGE = 2;
    localparam int B1_BOTTOM = 5;
    localparam int B1_SMALL = 6;
    localparam int B1_GUARD = 7;
    localparam int B2_LOCKDOWN = 0;
    localparam int B2_QUAD = 1;
    localparam int B2_SECLK = 3;
    localparam int B2_COMP = 6;
    localparam int B2_SUSP = 7;
    localparam int B3_SCHEME = 2;
    localparam int B3_DRV = 5;
    // software-writable bits per byte, reset values
    localparam logic [7:0] S1_WMASK = 8'hfc;
    localparam logic [7:0] S2_WMASK = 8'h43;
    localparam logic [7:0] S3_WMASK = 8'h64;
    localparam logic [7:0] S1_RST = 8'h00;
    localparam logic [7:0] S2_RST = 8'h00;
    localparam logic [7:0] S3_RST = 8'h00;
    // array geometry
    localparam logic [23:0] ARRAY_TOP = 24'h7fffff;
    localparam logic [23:0] BLOCK_UNIT = 24'h020000;
    localparam logic [23:0] SECTOR_UNIT = 24'h001000;
    localparam logic [23:0] PAGE_MASK = 24'h0000ff;
    localparam logic [23:0] SECT_MASK = 24'h000fff;
    localparam logic [23:0] HALF_MASK = 24'h007fff;
    localparam logic [23:0] BLK_MASK = 24'h00ffff;
    localparam int LOCK_BITS = 158;
    localparam logic [7:0] LOCK0_BASE = 8'h7e;
    localparam logic [7:0] LOCK127_BASE = 8'h8e;
    localparam logic [6:0] LAST_BLOCK = 7'h7f;
    localparam logic [2:0] ARG_MAX = 3'h4;
    // decoded protected address range
    typedef struct packed {
        logic none;
        logic [23:0] lo;
        logic [23:0] hi;
    } fsw_range_t;
    // one-time lock prefix sequence
    typedef enum logic [1:0] {PX_NONE, PX_FIRST, PX_ARMED} fsw_prefix_t;
endpackage

// File: fsw_spi_host.sv
// serial bus host model issuing status, lock and erase frames
`timescale 1ns/100ps
`default_nettype none
module fsw_spi_host (
    output logic SCLK, // link clock, stands low outside frames
    output logic CS_N, // chip select, active low
    output logic DI, // host to device data
    input wire logic DO // device to host data
);
    // idle bus at time zero
    initial begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        DI = 1'b0;
    end
    // whole bytes only, msb first, mode 0; rd keeps the last eight bits seen
    task automatic xfer(input logic [39:0] d, input int nb, output logic [7:0] rd);
        CS_N = 1'b0;
        for (int i = 0; i < nb * 8; i++) begin
            DI = d[39 - i];
            #40 SCLK = 1'b1;
            rd = {rd[6:0], DO};
            #40 SCLK = 1'b0;
        end
        #40 CS_N = 1'b1;
        DI = ~DI; // released line must not echo the last bit
        #600; // frame gap well above eight core cycles
    endtask
endmodule // fsw_spi_host
`default_nettype wire

// File: fsw_status_protect.sv
// status register write protection and array protection decode
`timescale 1ns/100ps
`default_nettype none
module fsw_status_protect
    import fsw_pkg::*;
(
    input wire logic REF_CLK, // core clock, 20 MHz
    input wire logic RST, // asynchronous reset, active high
    input wire logic SPI_CLK, // serial bus clock
    input wire logic CS_N, // chip select, active low
    input wire logic DI, // serial data in
    input wire logic WP_N, // write protect pin, active low
    output logic DO, // serial data out
    output logic DO_OE, // data out enable
    output logic QUAD_ENABLE, // IO2 and IO3 act as data lines
    output logic HOLD_ENABLE, // pause input active
    output logic [1:0] DRIVE_STRENGTH, // read output drive code
    output logic SUSPENDED, // suspend flag
    output logic [2:0] SEC_LOCKS, // security area locks
    output logic OP_ACCEPT, // program or erase may proceed, pulse
    output logic OP_REJECT // program or erase dropped, pulse
);
    // status bytes and private state
    logic [7:0] s1_q, s2_q, s3_q;
    logic otp_q;
    logic [LOCK_BITS-1:0] lk_q;
    fsw_prefix_t px_q;

    // ---------------- serial clock domain ----------------
    logic spi_rst;
    logic [2:0] bit_q;
    logic [7:0] shf_q, byte_q;
    logic tog_q, opc_seen_q, rd_q;
    logic [1:0] rd_sel_q;
    logic [7:0] shf_d, rd_byte;
    assign spi_rst = RST | CS_N;
    assign shf_d = {shf_q[6:0], DI};

    // bit counter and read decode end with the frame itself
    always_ff @(posedge SPI_CLK or posedge spi_rst) begin
        if (spi_rst) begin
            bit_q <= 3'h0;
            shf_q <= 8'h00;
            opc_seen_q <= 1'b0;
            rd_q <= 1'b0;
            rd_sel_q <= 2'h0;
        end else begin
            bit_q <= bit_q + 3'h1;
            shf_q <= shf_d;
            if (bit_q == 3'h7 && !opc_seen_q) begin
                opc_seen_q <= 1'b1;
                rd_q <= (shf_d == OP_RD_S1) || (shf_d == OP_RD_S2) || (shf_d == OP_RD_S3);
                rd_sel_q <= (shf_d == OP_RD_S2) ? 2'h1 : (shf_d == OP_RD_S3) ? 2'h2 : 2'h0;
            end
        end
    end

    // finished byte and event toggle survive chip select so no event is lost
    always_ff @(posedge SPI_CLK or posedge RST) begin
        if (RST) begin
            byte_q <= 8'h00;
            tog_q <= 1'b0;
        end else if (bit_q == 3'h7) begin
            byte_q <= shf_d;
            tog_q <= ~tog_q;
        end
    end

    // status bytes change only at frame end, so they are quasi-static while shifted out
    always_comb begin
        rd_byte = s1_q;
        if (rd_sel_q == 2'h1) begin
            rd_byte = s2_q;
        end else if (rd_sel_q == 2'h2) begin
            rd_byte = s3_q;
        end
    end

    // data out changes on the falling edge, msb first, bytes repeat
    always_ff @(negedge SPI_CLK or posedge spi_rst) begin
        if (spi_rst) begin
            DO <= 1'b0;
            DO_OE <= 1'b0;
        end else begin
            DO <= rd_byte[~bit_q];
            DO_OE <= rd_q;
        end
    end

    // ---------------- core clock domain ----------------
    logic tog_s1, tog_s2, tog_s3;
    logic cs_s1, cs_s2, cs_s3, cs_s4;
    logic wp_s1, wp_s2;
    logic byte_ev, frame_end;

    // two-flop synchronisers; the extra stage orders frame end after the last byte
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            {tog_s1, tog_s2, tog_s3} <= 3'h0;
            {cs_s1, cs_s2, cs_s3, cs_s4} <= 4'hf;
            {wp_s1, wp_s2} <= 2'h3;
        end else begin
            {tog_s1, tog_s2, tog_s3} <= {tog_q, tog_s1, tog_s2};
            {cs_s1, cs_s2, cs_s3, cs_s4} <= {CS_N, cs_s1, cs_s2, cs_s3};
            {wp_s1, wp_s2} <= {WP_N, wp_s1};
        end
    end
    assign byte_ev = tog_s2 ^ tog_s3;
    assign frame_end = cs_s3 & ~cs_s4;

    // collect opcode and up to three argument bytes of a frame
    logic [7:0] opc_q;
    logic [2:0] idx_q;
    logic [23:0] args_q;
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            opc_q <= 8'h00;
            idx_q <= 3'h0;
            args_q <= 24'h0;
        end else if (frame_end) begin
            idx_q <= 3'h0;
        end else if (byte_ev) begin
            if (idx_q == 3'h0) begin
                opc_q <= byte_q;
            end else if (idx_q < ARG_MAX) begin
                args_q <= {args_q[15:0], byte_q};
            end
            if (idx_q < ARG_MAX) begin
                idx_q <= idx_q + 3'h1;
            end
        end
    end

    // write gating; quad mode takes the protect pin out of the decision
    logic pin_block, wr_ok, is_wrs;
    assign is_wrs = (opc_q == OP_WR_S1) || (opc_q == OP_WR_S2) || (opc_q == OP_WR_S3);
    assign pin_block = s1_q[B1_GUARD] & ~wp_s2 & ~s2_q[B2_QUAD];
    assign wr_ok = s1_q[B1_WR_EN] & ~s2_q[B2_LOCKDOWN] & ~otp_q & ~pin_block;

    // new status byte values; reserved bits and read-only flags are kept
    logic [7:0] w1, w2;
    logic [7:0] n1, n2, n3;
    always_comb begin
        w1 = args_q[7:0];
        w2 = args_q[7:0];
        if (idx_q == 3'h3) begin
            w1 = args_q[15:8];
        end
        n1 = (s1_q & ~S1_WMASK) | (w1 & S1_WMASK);
        n2 = (s2_q & ~S2_WMASK) | (w2 & S2_WMASK);
        n2[B2_SECLK+:3] = s2_q[B2_SECLK+:3] | w2[B2_SECLK+:3];
        n3 = (s3_q & ~S3_WMASK) | (args_q[7:0] & S3_WMASK);
    end

    // protected range decode from the range fields
    fsw_range_t rng;
    logic [2:0] bp;
    logic [23:0] size;
    always_comb begin
        bp = s1_q[B1_RANGE+:3];
        size = BLOCK_UNIT << (bp - 3'h1);
        if (s1_q[B1_SMALL]) begin
            size = bp[2] ? (SECTOR_UNIT << 3) : (SECTOR_UNIT << (bp[1:0] - 2'h1));
        end
        rng.none = (bp == 3'h0);
        rng.lo = s1_q[B1_BOTTOM] ? 24'h0 : ARRAY_TOP - size + 24'h1;
        rng.hi = s1_q[B1_BOTTOM] ? size - 24'h1 : ARRAY_TOP;
        if (bp == 3'h7) begin
            rng.lo = 24'h0;
            rng.hi = ARRAY_TOP;
        end
    end

    // target region of the pending program or erase
    logic is_op, is_chip;
    logic [23:0] mask, r_lo, r_hi;
    always_comb begin
        is_chip = (opc_q == OP_CHIP_A) || (opc_q == OP_CHIP_B);
        is_op = is_chip || (opc_q == OP_PROG) || (opc_q == OP_QPROG) || (opc_q == OP_ERASE_4K)
            || (opc_q == OP_ERASE_32K) || (opc_q == OP_ERASE_64K);
        mask = PAGE_MASK;
        if (opc_q == OP_ERASE_4K) begin
            mask = SECT_MASK;
        end else if (opc_q == OP_ERASE_32K) begin
            mask = HALF_MASK;
        end else if (opc_q == OP_ERASE_64K) begin
            mask = BLK_MASK;
        end
        r_lo = is_chip ? 24'h0 : (args_q & ~mask);
        r_hi = is_chip ? ARRAY_TOP : (args_q | mask);
    end

    // lock bit index: middle blocks, then sectors of the bottom and top blocks
    logic [6:0] blk;
    logic [7:0] lk_idx;
    logic end_blk, lk_hit, rng_hit, op_ok;
    logic [15:0] sec_grp;
    always_comb begin
        blk = args_q[22:16];
        end_blk = (blk == 7'h0) || (blk == LAST_BLOCK);
        lk_idx = {1'b0, blk} - 8'h1;
        if (end_blk) begin
            lk_idx = ((blk == 7'h0) ? LOCK0_BASE : LOCK127_BASE) + {4'h0, args_q[15:12]};
        end
        sec_grp = (blk == 7'h0) ? lk_q[LOCK0_BASE+:16] : lk_q[LOCK127_BASE+:16];
        lk_hit = lk_q[lk_idx];
        if (is_chip) begin
            lk_hit = |lk_q;
        end else if (end_blk && (mask == HALF_MASK || mask == BLK_MASK)) begin
            lk_hit = |sec_grp;
        end
        // complement: only whole containment in the unprotected range is allowed
        if (s2_q[B2_COMP]) begin
            rng_hit = rng.none || r_lo < rng.lo || r_hi > rng.hi;
        end else begin
            rng_hit = !rng.none && r_lo <= rng.hi && r_hi >= rng.lo;
        end
        op_ok = (is_chip || idx_q == 3'h4) && s1_q[B1_WR_EN]
            && !(s3_q[B3_SCHEME] ? lk_hit : rng_hit);
    end

    // one-time lock prefix: AAh frame then 55h frame arms the next status write
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            px_q <= PX_NONE;
        end else if (frame_end) begin
            case (px_q)
                PX_NONE: begin
                    px_q <= (opc_q == OP_PREFIX_A) ? PX_FIRST : PX_NONE;
                end
                PX_FIRST: begin
                    px_q <= (opc_q == OP_PREFIX_B) ? PX_ARMED : PX_NONE;
                end
                default: begin
                    px_q <= PX_NONE;
                end
            endcase
        end
    end

    // permanent lock; reset leaves it set because it models a fused bit
    always_ff @(posedge REF_CLK) begin
        if (frame_end && px_q == PX_ARMED && wr_ok && opc_q == OP_WR_S2 && w2[B2_LOCKDOWN]) begin
            otp_q <= 1'b1;
        end else if (otp_q !== 1'b1) begin
            otp_q <= 1'b0;
        end
    end

    // status bytes; a refused write only clears the write enable latch and leaves the rest unchanged
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            s1_q <= S1_RST;
            s2_q <= S2_RST;
            s3_q <= S3_RST;
        end else if (frame_end) begin
            if (is_wrs && wr_ok) begin
                if (opc_q == OP_WR_S1) begin
                    s1_q <= n1;
                end
                if ((opc_q == OP_WR_S1 && idx_q == 3'h3) || opc_q == OP_WR_S2) begin
                    s2_q <= n2;
                end
                if (opc_q == OP_WR_S3) begin
                    s3_q <= n3;
                end
            end
            if (opc_q == OP_WR_EN) begin
                s1_q[B1_WR_EN] <= 1'b1;
            end else if (opc_q == OP_WR_DIS || is_wrs || is_op || opc_q == OP_LOCK_ONE
                || opc_q == OP_UNLOCK_ONE || opc_q == OP_LOCK_ALL || opc_q == OP_UNLOCK_ALL) begin
                s1_q[B1_WR_EN] <= 1'b0;
            end
            if (opc_q == OP_SUSPEND) begin
                s2_q[B2_SUSP] <= 1'b1;
            end else if (opc_q == OP_RESUME) begin
                s2_q[B2_SUSP] <= 1'b0;
            end
        end
    end

    // individual locks; all set at reset so the array starts protected
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            lk_q <= {LOCK_BITS{1'b1}};
        end else if (frame_end && s1_q[B1_WR_EN]) begin
            if (opc_q == OP_LOCK_ALL) begin
                lk_q <= {LOCK_BITS{1'b1}};
            end else if (opc_q == OP_UNLOCK_ALL) begin
                lk_q <= {LOCK_BITS{1'b0}};
            end else if (idx_q == 3'h4 && (opc_q == OP_LOCK_ONE || opc_q == OP_UNLOCK_ONE)) begin
                lk_q[lk_idx] <= (opc_q == OP_LOCK_ONE);
            end
        end
    end

    // registered outputs
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            OP_ACCEPT <= 1'b0;
            OP_REJECT <= 1'b0;
            QUAD_ENABLE <= 1'b0;
            HOLD_ENABLE <= 1'b1;
            DRIVE_STRENGTH <= 2'h0;
            SUSPENDED <= 1'b0;
            SEC_LOCKS <= 3'h0;
        end else begin
            OP_ACCEPT <= frame_end && is_op && op_ok;
            OP_REJECT <= frame_end && is_op && !op_ok;
            QUAD_ENABLE <= s2_q[B2_QUAD];
            HOLD_ENABLE <= ~s2_q[B2_QUAD];
            DRIVE_STRENGTH <= s3_q[B3_DRV+:2];
            SUSPENDED <= s2_q[B2_SUSP];
            SEC_LOCKS <= s2_q[B2_SECLK+:3];
        end
    end

    // checks on the core domain
    wel_clear_a: assert property (@(posedge REF_CLK) disable iff (RST)
        frame_end && is_wrs |=> !s1_q[B1_WR_EN]) else $error("latch not cleared after status write");
    lockdown_hold_a: assert property (@(posedge REF_CLK) disable iff (RST)
        frame_end && s2_q[B2_LOCKDOWN] && is_wrs |=> $stable(s1_q[7:2]) && $stable(s3_q))
        else $error("status changed under lockdown");
    pin_refuse_a: assert property (@(posedge REF_CLK) disable iff (RST)
        frame_end && is_wrs && s1_q[B1_GUARD] && !wp_s2 && !s2_q[B2_QUAD] |=> $stable(s3_q) && $stable(s1_q[7:2]))
        else $error("write taken with protect pin low");
    sw_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
        frame_end && opc_q == OP_WR_S1 && idx_q == 3'h2 && s1_q[B1_WR_EN] && !s1_q[B1_GUARD]
        && !s2_q[B2_LOCKDOWN] && !otp_q |=> s1_q[7:2] == $past(args_q[7:2]))
        else $error("software status write lost");
    sec_sticky_a: assert property (@(posedge REF_CLK) disable iff (RST)
        ($past(s2_q[B2_SECLK+:3]) & ~s2_q[B2_SECLK+:3]) == 3'h0) else $error("security lock bit cleared");
    suspend_set_a: assert property (@(posedge REF_CLK) disable iff (RST)
        frame_end && opc_q == OP_SUSPEND |=> s2_q[B2_SUSP] ##2 SUSPENDED) else $error("suspend flag not set");
    op_drop_a: assert property (@(posedge REF_CLK) disable iff (RST)
        frame_end && is_op && !s1_q[B1_WR_EN] |=> OP_REJECT && !OP_ACCEPT) else $error("unenabled operation taken");
    otp_keep_a: assert property (@(posedge REF_CLK) disable iff (RST)
        otp_q && frame_end && is_wrs |=> $stable(s1_q[7:2])) else $error("write taken after permanent lock");
    quad_pins_a: assert property (@(posedge REF_CLK) disable iff (RST)
        HOLD_ENABLE != QUAD_ENABLE) else $error("pause and quad both active");
endmodule // fsw_status_protect
`default_nettype wire

// File: fsw_status_protect_tb.sv
// self-checking bench for the status protection block
`timescale 1ns/100ps
`default_nettype none
module fsw_status_protect_tb;
    import fsw_pkg::*;
    logic ref_clk, rst, wp_n;
    wire logic sclk, cs_n, di, do_w, do_oe, quad, hold, susp, acc, rej;
    wire logic [1:0] drv;
    wire logic [2:0] secl;
    int miscompares = 0, total_checks = 0, n_acc = 0, n_rej = 0, unl = -1, n_oe = 0;
    logic [7:0] s1, s2, s3, rd;
    logic write_enable_latch, perm;
    logic [31:0] r, rng = 32'd38;
    logic [23:0] adr [8] = '{24'h0, 24'h001000, 24'h01f000, 24'h020000, 24'h7df000, 24'h7e0000, 24'h7f7000,
        24'h7f8000};
    fsw_spi_host host (.SCLK(sclk), .CS_N(cs_n), .DI(di), .DO(do_w));
    fsw_status_protect DUT (.REF_CLK(ref_clk), .RST(rst), .SPI_CLK(sclk), .CS_N(cs_n), .DI(di), .WP_N(wp_n),
        .DO(do_w), .DO_OE(do_oe), .QUAD_ENABLE(quad), .HOLD_ENABLE(hold), .DRIVE_STRENGTH(drv),
        .SUSPENDED(susp), .SEC_LOCKS(secl), .OP_ACCEPT(acc), .OP_REJECT(rej));
    // core clock, 50 ns
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // count one-cycle result pulses so no pulse is missed between frames
    always @(posedge ref_clk) begin
        n_acc <= n_acc + int'(acc === 1'b1);
        n_rej <= n_rej + int'(rej === 1'b1);
    end
    // link edges with data out enabled; a two-byte status read should drive exactly one byte
    always @(posedge sclk)
        n_oe <= n_oe + int'(do_oe === 1'b1);
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // pulse counts packed as accept then reject nibble
    task automatic chk_op(input int a, input int n, input bit ok);
        chk8({a[3:0], n[3:0]}, ok ? 8'h10 : 8'h01);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // model: may a status write land now
    function automatic bit wr_ok();
        return write_enable_latch && !s2[B2_LOCKDOWN] && !perm && !(s1[B1_GUARD] && !wp_n && !s2[B2_QUAD]);
    endfunction
    // model: is the 4KB sector holding a protected
    function automatic bit prot(input int a);
        int bp = int'(s1[B1_RANGE +: 3]);
        int sz;
        bit hit;
        if (s3[B3_SCHEME])
            return (a & 32'hfff000) != unl;
        if (s1[B1_SMALL])
            sz = 4096 << ((bp >= 4) ? 3 : bp - 1);
        else
            sz = 131072 << (bp - 1);
        hit = s1[B1_BOTTOM] ? a < sz : a >= 32'h800000 - sz;
        if (bp == 0)
            hit = 0;
        if (bp == 7)
            hit = 1;
        return hit ^ s2[B2_COMP];
    endfunction
    task automatic wren();
        host.xfer({OP_WR_EN, 32'h0}, 1, rd);
        write_enable_latch = 1'b1;
    endtask
    task automatic rds(input logic [7:0] op, input logic [7:0] e);
        int k;
        k = n_oe;
        host.xfer({op, 32'h0}, 2, rd);
        chk8(rd & 8'hfd, e & 8'hfd);
        chk8(8'(n_oe - k), 8'h08);
    endtask
    task automatic verify();
        rds(OP_RD_S1, s1);
        rds(OP_RD_S2, s2);
        rds(OP_RD_S3, s3);
        chk8({quad, hold, drv, susp, secl}, {s2[B2_QUAD], ~s2[B2_QUAD], s3[B3_DRV +: 2], s2[B2_SUSP],
            s2[B2_SECLK +: 3]});
    endtask
    // status write; reserved bits always sent as zero
    task automatic wrs(input logic [7:0] op, input logic [7:0] v);
        logic [7:0] m;
        bit ok;
        m = (op == OP_WR_S1) ? S1_WMASK : (op == OP_WR_S2) ? (S2_WMASK | 8'h38) : S3_WMASK;
        v = v & m;
        wren();
        ok = wr_ok();
        host.xfer({op, v, 24'h0}, 2, rd);
        if (ok && op == OP_WR_S1)
            s1 = (s1 & ~m) | v;
        if (ok && op == OP_WR_S2)
            s2 = (s2 & ~m) | v | (s2 & 8'h38);
        if (ok && op == OP_WR_S3)
            s3 = (s3 & ~m) | v;
        write_enable_latch = 1'b0;
        verify();
    endtask
    // program or erase; any protected sector inside drops the whole command
    task automatic er(input logic [7:0] op, input logic [23:0] a, input bit en = 1'b1);
        int na, nr;
        bit ok;
        if (en)
            wren();
        ok = en;
        for (int k = 0; k < ((op == OP_ERASE_64K) ? 16 : 1); k++)
            if (prot(int'(a) + k * 4096))
                ok = 0;
        na = n_acc;
        nr = n_rej;
        host.xfer({op, a, 8'ha5}, (op == OP_PROG) ? 5 : 4, rd);
        write_enable_latch = 1'b0;
        chk_op(n_acc - na, n_rej - nr, ok);
    endtask
    task automatic setwp(input logic v);
        @(posedge ref_clk) wp_n <= v;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic pulse_rst();
        @(posedge ref_clk) rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        {s1, s2, s3, write_enable_latch, unl} = {24'h0, 1'b0, -32'sd1};
    endtask
    // hang guard
    initial begin
        #3000000;
        miscompares++;
        wrap_up();
    end
    // main sequence
    initial begin
        rst = 1'b1;
        wp_n = 1'b1;
        {s1, s2, s3, write_enable_latch, perm} = '0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        verify();
        host.xfer({OP_WR_S1, 8'h1c, 24'h0}, 2, rd);
        verify();
        wren();
        host.xfer({OP_RD_S1, 32'h0}, 2, rd);
        chk8(rd & 8'h02, 8'h02);
        wrs(OP_WR_S1, 8'h1c);
        host.xfer({OP_RD_S1, 32'h0}, 2, rd);
        chk8(rd & 8'h02, 8'h00);
        wrs(OP_WR_S1, 8'h80);
        setwp(1'b0);
        wrs(OP_WR_S1, 8'h9c);
        wrs(OP_WR_S2, 8'h02);
        setwp(1'b1);
        wrs(OP_WR_S1, 8'h8c);
        wrs(OP_WR_S2, 8'h02);
        setwp(1'b0);
        wrs(OP_WR_S1, 8'h00);
        setwp(1'b1);
        wrs(OP_WR_S2, 8'h00);
        for (int i = 0; i < 4; i++)
            wrs(OP_WR_S3, 8'(i << 5));
        host.xfer({OP_SUSPEND, 32'h0}, 1, rd);
        s2[B2_SUSP] = 1'b1;
        verify();
        host.xfer({OP_RESUME, 32'h0}, 1, rd);
        s2[B2_SUSP] = 1'b0;
        verify();
        wrs(OP_WR_S2, 8'h08);
        wrs(OP_WR_S2, 8'h20);
        wrs(OP_WR_S2, 8'h00);
        for (int i = 0; i < 8; i++) begin
            r = xs();
            wrs(OP_WR_S1, {1'b0, r[1:0], 3'(i), 2'b00});
            wrs(OP_WR_S2, {1'b0, r[2], 6'h00});
            foreach (adr[j])
                er(OP_ERASE_4K, adr[j]);
            er(OP_PROG, {1'b0, r[22:8], 8'h00});
            er(OP_ERASE_64K, r[3] ? 24'h7f0000 : 24'h000000);
        end
        er(OP_ERASE_4K, 24'h400000, 1'b0);
        wrs(OP_WR_S1, 8'h00);
        wrs(OP_WR_S3, 8'h04);
        er(OP_ERASE_4K, 24'h000000);
        wren();
        host.xfer({OP_UNLOCK_ONE, 24'h0, 8'h0}, 4, rd);
        unl = 0;
        er(OP_ERASE_4K, 24'h000000);
        er(OP_ERASE_4K, 24'h001000);
        er(OP_ERASE_4K, 24'h010000);
        wrs(OP_WR_S3, 8'h00);
        // two data bytes after 01h write the first and then the second status byte
        wren();
        host.xfer({OP_WR_S1, 8'h08, 8'h40, 16'h0}, 3, rd);
        s1 = 8'h08;
        s2 = (s2 & ~S2_WMASK) | 8'h40;
        write_enable_latch = 1'b0;
        verify();
        wrs(OP_WR_S2, 8'h01);
        wrs(OP_WR_S1, 8'h1c);
        pulse_rst();
        verify();
        wrs(OP_WR_S1, 8'h0c);
        // latch first: any frame between the prefix and the write would disarm it
        wren();
        host.xfer({OP_PREFIX_A, 32'h0}, 1, rd);
        host.xfer({OP_PREFIX_B, 32'h0}, 1, rd);
        host.xfer({OP_WR_S2, 8'h01, 24'h0}, 2, rd);
        {s2[B2_LOCKDOWN], write_enable_latch, perm} = 3'b101;
        verify();
        pulse_rst();
        wrs(OP_WR_S1, 8'h1c);
        wrap_up();
    end
endmodule // fsw_status_protect_tb
`default_nettype wire
